// ---- rtl/ormv_exec.sv ----
`timescale 1ns/1ps
// Behaviour
// - or literal into acc, zero flag only
// - load literal into acc, flags untouched
// - or acc with register, zero flag
// - d=0 result to acc, d=1 register
// - move register to acc or itself
// - move updates zero flag both destinations
// - 7-bit address, one destination bit
module ormv_exec
    import ormv_pkg::*;
(
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    input  wire logic                          instr_valid,
    input  wire logic [ormv_pkg::INSTR_W-1:0]  instr,
    input  wire logic [ormv_pkg::DATA_W-1:0]   reg_rdata,
    output logic [ormv_pkg::ADDR_W-1:0]        reg_raddr,
    output logic [ormv_pkg::DATA_W-1:0]        acc,
    output logic                               zero_flag,
    output logic                               reg_we,
    output logic [ormv_pkg::ADDR_W-1:0]        reg_waddr,
    output logic [ormv_pkg::DATA_W-1:0]        reg_wdata
);
    import ormv_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic              zero_flag;
        logic              reg_we;
        logic [ADDR_W-1:0] reg_waddr;
        logic [DATA_W-1:0] reg_wdata;
    } ormv_state_t;

    ormv_state_t       state;
    ormv_state_t       next_state;
    ormv_op_t          op;
    logic [DATA_W-1:0] literal;
    logic [ADDR_W-1:0] addr;
    logic              dest_reg;

    ormv_decode u_decode (
        .instr    (instr),
        .op       (op),
        .literal  (literal),
        .reg_addr (addr),
        .dest_reg (dest_reg)
    );

    // read address is combinational so the register file answers same cycle
    assign reg_raddr = addr;

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    always_comb begin
        logic [DATA_W-1:0] result;
        result            = '0;
        next_state        = state;
        next_state.reg_we = 1'b0;  // write strobe lasts one cycle
        if (instr_valid) begin
            unique case (op)
                ORMV_ORLIT: begin
                    result               = state.acc | literal;
                    next_state.acc       = result;
                    next_state.zero_flag = (result == '0);
                end
                ORMV_LDLIT: begin
                    next_state.acc = literal;
                end
                ORMV_ORREG: begin
                    result               = state.acc | reg_rdata;
                    next_state.zero_flag = (result == '0);
                    if (dest_reg) begin
                        next_state.reg_we    = 1'b1;
                        next_state.reg_waddr = addr;
                        next_state.reg_wdata = result;
                    end else begin
                        next_state.acc = result;
                    end
                end
                ORMV_MOVREG: begin
                    result               = reg_rdata;
                    next_state.zero_flag = (result == '0);
                    if (dest_reg) begin
                        next_state.reg_we    = 1'b1;
                        next_state.reg_waddr = addr;
                        next_state.reg_wdata = result;
                    end else begin
                        next_state.acc = result;
                    end
                end
                ORMV_NONE: begin
                    result = '0;
                end
            endcase
        end
    end

    // single-cycle completion, no wait states
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state.acc       <= ACC_RESET;
            state.zero_flag <= ZERO_RESET;
            state.reg_we    <= 1'b0;
            state.reg_waddr <= '0;
            state.reg_wdata <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign acc       = state.acc;
    assign zero_flag = state.zero_flag;
    assign reg_we    = state.reg_we;
    assign reg_waddr = state.reg_waddr;
    assign reg_wdata = state.reg_wdata;
endmodule

// ---- rtl/ormv_pkg.sv ----
package ormv_pkg;

    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int INSTR_W      = 14;
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 7;
    localparam int LIT_LSB      = 0;
    localparam int ADDR_LSB     = 0;
    localparam int DEST_BIT     = 7;
    localparam int OP_LSB       = 8;
    localparam int OP_W         = 6;

    // ------------------------------------------------------------
    // opcodes, upper six bits
    // ------------------------------------------------------------
    localparam logic [5:0] OP_OR_LITERAL   = 6'h38;
    localparam logic [5:0] OP_LOAD_MASK    = 6'h3C;
    localparam logic [5:0] OP_LOAD_LITERAL = 6'h30;
    localparam logic [5:0] OP_OR_REGISTER  = 6'h04;
    localparam logic [5:0] OP_MOVE_REG     = 6'h08;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RESET  = 8'h00;
    localparam logic       ZERO_RESET = 1'b0;

    typedef enum logic [4:0] {
        ORMV_NONE   = 5'b00001,
        ORMV_ORLIT  = 5'b00010,
        ORMV_LDLIT  = 5'b00100,
        ORMV_ORREG  = 5'b01000,
        ORMV_MOVREG = 5'b10000
    } ormv_op_t;

endpackage

// ---- rtl/ormv_decode.sv ----
`timescale 1ns/1ps
module ormv_decode
    import ormv_pkg::*;
(
    input  wire logic [ormv_pkg::INSTR_W-1:0] instr,
    output ormv_pkg::ormv_op_t                op,
    output logic [ormv_pkg::DATA_W-1:0]       literal,
    output logic [ormv_pkg::ADDR_W-1:0]       reg_addr,
    output logic                              dest_reg
);
    logic [OP_W-1:0] opcode;

    always_comb begin
        opcode   = instr[OP_LSB +: OP_W];
        literal  = instr[LIT_LSB +: DATA_W];
        reg_addr = instr[ADDR_LSB +: ADDR_W];
        dest_reg = instr[DEST_BIT];
        if (opcode == OP_OR_LITERAL) begin
            op = ORMV_ORLIT;
        // don't-care bits masked off
        end else if ((opcode & OP_LOAD_MASK) == OP_LOAD_LITERAL) begin
            op = ORMV_LDLIT;
        end else if (opcode == OP_OR_REGISTER) begin
            op = ORMV_ORREG;
        end else if (opcode == OP_MOVE_REG) begin
            op = ORMV_MOVREG;
        end else begin
            op = ORMV_NONE;
        end
    end
endmodule

// ---- test/ormv_monitor.sv ----
`timescale 1ns/1ps
module ormv_monitor
    import ormv_pkg::*;
(
    input wire logic                         ref_clk,
    input wire logic                         reset,
    input wire logic                         instr_valid,
    input wire logic [ormv_pkg::INSTR_W-1:0] instr,
    input wire logic [ormv_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic [ormv_pkg::ADDR_W-1:0]  reg_raddr,
    input wire logic [ormv_pkg::DATA_W-1:0]  acc,
    input wire logic                         zero_flag,
    input wire logic                         reg_we,
    input wire logic [ormv_pkg::ADDR_W-1:0]  reg_waddr,
    input wire logic [ormv_pkg::DATA_W-1:0]  reg_wdata
);
    // ----
    // checks
    // ----
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [5:0] op;
    // idle folds to zero, no opcode is zero
    assign op = instr_valid ? instr[13:8] : 6'h00;
    sequence s_wb; reg_we ##0 $stable(acc); endsequence
    property p_orl; op == OP_OR_LITERAL |=> acc == ($past(acc) | $past(instr[7:0]))
        && zero_flag == (acc == 8'h00) && !reg_we; endproperty
    a_orl: assert property (p_orl) else $error("or literal");
    property p_ldl; op[5:2] == 4'hC |=> acc == $past(instr[7:0])
        && $stable(zero_flag) && !reg_we; endproperty
    a_ldl: assert property (p_ldl) else $error("load literal");
    property p_orr; op == OP_OR_REGISTER && !instr[7] |=>
        acc == ($past(acc) | $past(reg_rdata)) && zero_flag == (acc == 8'h00); endproperty
    a_orr: assert property (p_orr) else $error("or reg to acc");
    property p_orw; op == OP_OR_REGISTER && instr[7] |=> s_wb ##0
        (reg_wdata == ($past(acc) | $past(reg_rdata)) && zero_flag == (reg_wdata == 8'h00));
    endproperty
    a_orw: assert property (p_orw) else $error("or reg writeback");
    property p_mvr; op == OP_MOVE_REG && !instr[7] |=>
        acc == $past(reg_rdata) && zero_flag == (acc == 8'h00); endproperty
    a_mvr: assert property (p_mvr) else $error("move to acc");
    property p_mvw; op == OP_MOVE_REG && instr[7] |=> s_wb ##0
        (reg_wdata == $past(reg_rdata) && zero_flag == (reg_wdata == 8'h00)); endproperty
    a_mvw: assert property (p_mvw) else $error("move writeback");
    property p_adr; reg_raddr == instr[6:0]
        && (!reg_we || reg_waddr == $past(instr[6:0])); endproperty
    a_adr: assert property (p_adr) else $error("address");
    property p_idl; op == 6'h00 |=> !reg_we && $stable(acc) && $stable(zero_flag);
    endproperty
    a_idl: assert property (p_idl) else $error("idle change");
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
bind ormv_exec ormv_monitor i_mon (.ref_clk(ref_clk), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .reg_rdata(reg_rdata), .reg_raddr(reg_raddr),
    .acc(acc), .zero_flag(zero_flag), .reg_we(reg_we), .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata));
module tb;
    // ----
    // bench
    // ----
    logic        ref_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, zero_flag, reg_we;
    logic [13:0] instr = 14'h0000;
    logic [7:0]  reg_rdata = 8'h00, acc, reg_wdata;
    logic [6:0]  reg_raddr, reg_waddr;
    int          n_fail = 0, check_count = 0;
    ormv_exec i_dut (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
        .instr(instr), .reg_rdata(reg_rdata), .reg_raddr(reg_raddr), .acc(acc),
        .zero_flag(zero_flag), .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata));
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // write address and data only judged with a write pulse
    task automatic ex(input logic v, input logic [13:0] w, input logic [7:0] rd,
        input logic [7:0] a, input logic [1:0] zw, input logic [14:0] wd);
        @(posedge ref_clk);
        instr <= w;
        reg_rdata <= rd;
        instr_valid <= v;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        reg_rdata <= ~rd;
        #1;
        check_count++;
        if ({acc, zero_flag, reg_we} !== {a, zw} || reg_raddr !== w[6:0]
            || (zw[0] && {reg_waddr, reg_wdata} !== wd)) begin
            n_fail++;
            $display("wrong value at %0t: word %h", $time, w);
        end
    endtask
    task automatic t_literal;
        ex(1, 14'h309A, 8'h00, 8'h9A, 2'b00, 15'h0);
        ex(1, 14'h3835, 8'h00, 8'hBF, 2'b00, 15'h0);
        ex(1, 14'h3300, 8'h00, 8'h00, 2'b00, 15'h0);
        ex(1, 14'h3800, 8'h00, 8'h00, 2'b10, 15'h0);
        ex(1, 14'h3391, 8'h00, 8'h91, 2'b10, 15'h0);
    endtask
    task automatic t_orreg;
        ex(1, 14'h0413, 8'h13, 8'h93, 2'b00, 15'h0);
        ex(1, 14'h3000, 8'h00, 8'h00, 2'b00, 15'h0);
        ex(1, 14'h0405, 8'h00, 8'h00, 2'b10, 15'h0);
        ex(1, 14'h04FF, 8'h20, 8'h00, 2'b01, {7'h7F, 8'h20});
        ex(0, 14'h04FF, 8'h20, 8'h00, 2'b00, 15'h0);
    endtask
    task automatic t_move;
        ex(1, 14'h305A, 8'h00, 8'h5A, 2'b00, 15'h0);
        ex(1, 14'h0813, 8'h00, 8'h00, 2'b10, 15'h0);
        ex(1, 14'h08C5, 8'h44, 8'h00, 2'b01, {7'h45, 8'h44});
        ex(1, 14'h0880, 8'h00, 8'h00, 2'b11, 15'h0);
        ex(1, 14'h3900, 8'h00, 8'h00, 2'b10, 15'h0);
    endtask
    // mid-run reset must clear everything, then execution resumes cleanly
    task automatic t_reset;
        ex(1, 14'h30A5, 8'h00, 8'hA5, 2'b10, 15'h0);
        @(posedge ref_clk);
        reset <= 1'b1;
        @(posedge ref_clk);
        #1;
        check_count++;
        if ({acc, zero_flag, reg_we, reg_waddr, reg_wdata} !== 25'h0) begin
            n_fail++;
            $display("wrong value at %0t: reset values", $time);
        end
        @(posedge ref_clk);
        reset <= 1'b0;
        ex(1, 14'h3811, 8'h00, 8'h11, 2'b00, 15'h0);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        t_literal;
        t_orreg;
        t_move;
        t_reset;
        conclude;
    end
    // runs take about 53 cycles
    initial begin
        #5000;
        n_fail++;
        conclude;
    end
endmodule
